// ---- dctv_defines.svh ----
/*
 * Constants for the timer-setup, verify, version and write command engine:
 * register offsets, field positions, opcodes, status bits and time scales.
 * Assumes inclusion by the engine and the testbench only.
 */
`ifndef DCTV_DEFINES_SVH
`define DCTV_DEFINES_SVH

// apb word offsets
`define DCTV_REG_CMD 8'h00
`define DCTV_REG_RESULT 8'h04
`define DCTV_REG_STATUS 8'h08
`define DCTV_REG_TIMERS 8'h0C
`define DCTV_REG_SECTORS 8'h10

// command opcodes, low five bits of the first byte
`define DCTV_OP_SPECIFY 5'h03
`define DCTV_OP_VERIFY 5'h16
`define DCTV_OP_VERSION 5'h10
`define DCTV_OP_WRITE 5'h05
`define DCTV_VERSION_BYTE 8'h5A
`define DCTV_INVALID_BYTE 8'h80
`define DCTV_BAD_TRACK 8'hFF

// status bit positions
`define DCTV_S1_EOT 7
`define DCTV_S1_CRC 5
`define DCTV_S1_OVERRUN 4
`define DCTV_S1_NO_DATA 2
`define DCTV_S1_PROTECT 1
`define DCTV_S1_MISSING 0
`define DCTV_S2_WRONG_TRACK 4
`define DCTV_S2_BAD_TRACK 1

// time base: one tick of 1/6 ms scales every rate factor to an integer
`define DCTV_CLK_HZ 25000000
`define DCTV_TICK_PER_MS 6
`define DCTV_TICK_CYCLES (`DCTV_CLK_HZ / 1000 / `DCTV_TICK_PER_MS)

`endif

// ---- dctv_pkg.sv ----
/*
 * Types for the command engine.
 * Assumes dctv_defines.svh is on the include path.
 */
package dctv_pkg;
	typedef enum logic [3:0] {
		DCTV_IDLE, DCTV_PARAMS, DCTV_MOTOR, DCTV_SEEK, DCTV_SEARCH,
		DCTV_GAP, DCTV_DATA, DCTV_NEXT, DCTV_RESULT
	} dctv_state_e;
endpackage

// ---- dctv_engine.sv ----
/*
 * Command engine for timer setup, sector verify, version query and sector
 * write, with an apb register window.
 * Assumes drive inputs arrive asynchronously and a separator that delivers
 * decoded address fields and takes write bytes with a one-cycle strobe.
 */
// Register access over APB and the address map were decided locally.
// Notes on behaviour
// - specify takes two bytes, returns none
// - step spacing from step code and rate
// - motor-off delay is code times rate factor
// - motor-off code zero counts as sixteen
// - motor-on delay is code times rate factor
// - motor-on code zero counts as 128
// - mode bit selects dma or programmed transfer
// - timers only delay command start
// - verify checks marks and crc, no data
// - count-enable ends after count; zero is 256
// - end sector beyond track size aborts verify
// - terminal count ignored during verify
// - multitrack count continues side one, overflow aborts
// - version query returns one fixed byte
// - write waits motor-on then implied seek
// - compare address fields until one matches
// - two index pulses without match abort with flags
// - address crc error aborts with crc flag
// - write-protect aborts with status1 bit 1
// - fifo write aborts or unhangs write
// - wait second gap then write data
// - step code governs seek pulse rate
`include "dctv_defines.svh"
module dctv_engine
	import dctv_pkg::*;
#(
	parameter int GAP_CYCLES = 22,
	parameter int GAP_PERP_CYCLES = 11,
	parameter logic [7:0] SECTORS_PER_SIDE = 8'd18,
	parameter logic [7:0] VERSION_CODE = `DCTV_VERSION_BYTE // arbitrary value
) (
	input wire logic sys_clk_in,
	input wire logic sys_rst_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire logic [1:0] data_rate_in,
	input wire logic perpendicular_in,
	input wire logic implied_seek_select_in,
	input wire logic tc_in,
	input wire logic index_in,
	input wire logic write_protect_in,
	input wire logic id_valid_in,
	input wire logic id_crc_err_in,
	input wire logic [7:0] id_track_in,
	input wire logic [7:0] id_head_in,
	input wire logic [7:0] id_sector_in,
	input wire logic [7:0] id_size_in,
	input wire logic data_done_in,
	input wire logic data_crc_err_in,
	input wire logic mark_missing_in,
	input wire logic wr_byte_ready_in,
	output logic step_out,
	output logic sep_enable_out,
	output logic wr_gate_out,
	output logic [7:0] wr_byte_out,
	output logic wr_byte_valid_out,
	output logic dma_request_out,
	output logic dma_mode_out,
	output logic [7:0] head_select_out
);
	typedef struct packed {
		logic [2:0] index_sync;
		logic [1:0] tc_sync;
		logic [1:0] wp_sync;
		dctv_state_e state;
		logic [4:0] opcode;
		logic multitrack_flag;
		logic count_enable;
		logic implied_seek;
		logic [3:0] nbytes;
		logic [7:0] track;
		logic [7:0] head;
		logic [7:0] sector;
		logic [7:0] size;
		logic [7:0] end_of_track_sector;
		logic [7:0] data_length_param;
		logic [8:0] remaining;
		logic [3:0] step_interval_code;
		logic [3:0] motor_off_code;
		logic [6:0] motor_on_code;
		logic timer_mode_select;
		logic dma_mode;
		logic [15:0] tick_div;
		logic [19:0] delay_ticks;
		logic [19:0] step_ticks;
		logic step;
		logic [1:0] index_seen;
		logic any_mark;
		logic track_miss;
		logic [7:0] gap_cnt;
		logic [7:0] status_reg_0;
		logic [7:0] status_reg_1;
		logic [7:0] status_reg_2;
		logic [2:0] res_idx;
		logic [7:0] wr_byte;
		logic wr_valid;
		logic [31:0] rdata;
		logic ack;
	} dctv_regs_s;

	dctv_regs_s r;
	dctv_regs_s next_r;

	// tick counts per unit code, in 1/6 ms, for rates 1M, 500k, 300k, 250k
	function automatic logic [19:0] rate_scale(input logic [1:0] rate, input logic [19:0] m1,
		input logic [19:0] m5, input logic [19:0] m3, input logic [19:0] m2);
		unique case (rate)
			2'd0: rate_scale = m1;
			2'd1: rate_scale = m5;
			2'd2: rate_scale = m3;
			default: rate_scale = m2;
		endcase
	endfunction

	function automatic logic [19:0] motor_on_ticks(input logic [6:0] code, input logic mode,
		input logic [1:0] rate);
		logic [19:0] n;
		n = (code == 7'd0) ? 20'd128 : {13'd0, code};
		motor_on_ticks = mode ? n * rate_scale(rate, 20'd192, 20'd192, 20'd320, 20'd384)
			: n * rate_scale(rate, 20'd6, 20'd6, 20'd20, 20'd24);
	endfunction

	function automatic logic [19:0] motor_off_ticks(input logic [3:0] code, input logic mode,
		input logic [1:0] rate);
		logic [19:0] n;
		n = (code == 4'd0) ? 20'd16 : {16'd0, code};
		motor_off_ticks = mode ? n * rate_scale(rate, 20'd3072, 20'd3072, 20'd5120, 20'd6144)
			: n * rate_scale(rate, 20'd48, 20'd96, 20'd160, 20'd192);
	endfunction

	function automatic logic [19:0] step_gap_ticks(input logic [3:0] code,
		input logic [1:0] rate);
		logic [19:0] n;
		n = 20'd16 - {16'd0, code};
		step_gap_ticks = n * rate_scale(rate, 20'd3, 20'd6, 20'd10, 20'd12);
	endfunction

	logic wr_access;
	logic rd_access;
	logic tick;
	logic id_match;
	logic last_sector;

	always_comb begin
		// only the first access cycle acts, the ready cycle repeats nothing
		wr_access = psel_in & penable_in & pwrite_in & ~r.ack;
		rd_access = psel_in & penable_in & ~pwrite_in & ~r.ack;
		tick = (r.tick_div == 16'(`DCTV_TICK_CYCLES - 1));
		id_match = (id_track_in == r.track) && (id_head_in == r.head)
			&& (id_sector_in == r.sector) && (id_size_in == r.size);
		last_sector = (r.sector == r.end_of_track_sector);
	end

	always_comb begin
		next_r = r;
		next_r.index_sync = {r.index_sync[1:0], index_in};
		next_r.tc_sync = {r.tc_sync[0], tc_in};
		next_r.wp_sync = {r.wp_sync[0], write_protect_in};
		next_r.tick_div = tick ? 16'd0 : r.tick_div + 16'd1;
		next_r.step = 1'b0;
		next_r.wr_valid = r.wr_valid & ~wr_byte_ready_in;
		// one wait state: ready follows the first access cycle
		next_r.ack = psel_in & penable_in & ~r.ack;
		// free-running step pacing for seek pulses
		if (tick) begin
			if (r.step_ticks == 20'd0) begin
				// reload one short so the zero tick closes the interval
				next_r.step_ticks = step_gap_ticks(r.step_interval_code, data_rate_in)
					- 20'd1;
			end else begin
				next_r.step_ticks = r.step_ticks - 20'd1;
			end
		end
		if (rd_access) begin
			unique case (paddr_in)
				`DCTV_REG_RESULT: begin
					if (r.state == DCTV_RESULT) begin
						next_r.res_idx = r.res_idx + 3'd1;
						if (r.opcode == `DCTV_OP_VERSION || r.res_idx == 3'd6) begin
							next_r.state = DCTV_IDLE;
						end
					end
				end
				default: ;
			endcase
		end
		unique case (r.state)
			DCTV_IDLE: begin
				if (wr_access && paddr_in == `DCTV_REG_CMD) begin
					next_r.opcode = pwdata_in[4:0];
					next_r.multitrack_flag = pwdata_in[7];
					next_r.nbytes = 4'd0;
					next_r.res_idx = 3'd0;
					next_r.status_reg_0 = 8'h00;
					next_r.status_reg_1 = 8'h00;
					next_r.status_reg_2 = 8'h00;
					if (pwdata_in[4:0] == `DCTV_OP_VERSION) begin
						next_r.state = DCTV_RESULT;
					end else if (pwdata_in[4:0] == `DCTV_OP_SPECIFY
						|| pwdata_in[4:0] == `DCTV_OP_VERIFY
						|| pwdata_in[4:0] == `DCTV_OP_WRITE) begin
						next_r.state = DCTV_PARAMS;
					end else begin
						next_r.status_reg_0 = `DCTV_INVALID_BYTE;
						next_r.opcode = `DCTV_OP_VERSION;
						next_r.state = DCTV_RESULT;
					end
				end
			end
			DCTV_PARAMS: begin
				if (wr_access && paddr_in == `DCTV_REG_CMD) begin
					next_r.nbytes = r.nbytes + 4'd1;
					if (r.opcode == `DCTV_OP_SPECIFY) begin
						if (r.nbytes == 4'd0) begin
							next_r.step_interval_code = pwdata_in[7:4];
							next_r.motor_off_code = pwdata_in[3:0];
						end else begin
							next_r.motor_on_code = pwdata_in[7:1];
							next_r.dma_mode = pwdata_in[0];
							next_r.state = DCTV_IDLE;
						end
					end else begin
						unique case (r.nbytes)
							4'd0: begin
								next_r.count_enable = pwdata_in[7];
								next_r.implied_seek = pwdata_in[7] | implied_seek_select_in;
							end
							4'd1: next_r.track = pwdata_in[7:0];
							4'd2: next_r.head = pwdata_in[7:0];
							4'd3: next_r.sector = pwdata_in[7:0];
							4'd4: next_r.size = pwdata_in[7:0];
							4'd5: next_r.end_of_track_sector = pwdata_in[7:0];
							4'd6: ;
							default: begin
								next_r.data_length_param = pwdata_in[7:0];
								next_r.remaining = (pwdata_in[7:0] == 8'd0) ? 9'd256
									: {1'b0, pwdata_in[7:0]};
								next_r.delay_ticks = motor_on_ticks(r.motor_on_code,
									r.timer_mode_select, data_rate_in);
								next_r.state = DCTV_MOTOR;
							end
						endcase
						if (r.opcode == `DCTV_OP_VERIFY) begin
							next_r.implied_seek = implied_seek_select_in;
						end
					end
				end
			end
			DCTV_MOTOR: begin
				// delay only, no motor line is touched
				if (tick) begin
					next_r.delay_ticks = r.delay_ticks - 20'd1;
				end
				if (r.delay_ticks == 20'd0) begin
					next_r.state = r.implied_seek ? DCTV_SEEK : DCTV_SEARCH;
					next_r.index_seen = 2'd0;
					next_r.any_mark = 1'b0;
					next_r.track_miss = 1'b0;
					if (r.opcode == `DCTV_OP_VERIFY && (r.end_of_track_sector > SECTORS_PER_SIDE
						|| (r.count_enable && r.remaining > (r.multitrack_flag
						? {r.end_of_track_sector, 1'b0} : {1'b0, r.end_of_track_sector})))) begin
						next_r.status_reg_0 = 8'h40;
						next_r.state = DCTV_RESULT;
					end
				end
			end
			DCTV_SEEK: begin
				// one pacing interval stands in for the implied seek and sense
				if (tick && r.step_ticks == 20'd0) begin
					next_r.step = 1'b1;
					next_r.state = DCTV_SEARCH;
				end
			end
			DCTV_SEARCH: begin
				if (r.index_sync[2] & ~r.index_sync[1]) begin
					next_r.index_seen = r.index_seen + 2'd1;
				end
				if (r.opcode == `DCTV_OP_WRITE && r.wp_sync[1]) begin
					next_r.status_reg_1[`DCTV_S1_PROTECT] = 1'b1;
					next_r.status_reg_0 = 8'h40;
					next_r.state = DCTV_RESULT;
				end else if (wr_access && paddr_in == `DCTV_REG_CMD) begin
					next_r.status_reg_0 = 8'h40;
					next_r.state = DCTV_RESULT;
				end else if (id_valid_in) begin
					next_r.any_mark = 1'b1;
					if (id_crc_err_in) begin
						next_r.status_reg_1[`DCTV_S1_CRC] = 1'b1;
						next_r.status_reg_0 = 8'h40;
						next_r.state = DCTV_RESULT;
					end else if (id_match) begin
						next_r.gap_cnt = perpendicular_in ? 8'(GAP_PERP_CYCLES) : 8'(GAP_CYCLES);
						next_r.state = (r.opcode == `DCTV_OP_WRITE) ? DCTV_GAP : DCTV_DATA;
					end else if (id_track_in != r.track) begin
						next_r.track_miss = 1'b1;
					end
				end else if (r.index_seen == 2'd2) begin
					next_r.status_reg_0 = 8'h40;
					if (!r.any_mark) begin
						next_r.status_reg_1[`DCTV_S1_MISSING] = 1'b1;
					end else if (r.track_miss) begin
						if (r.track == `DCTV_BAD_TRACK) begin
							next_r.status_reg_2[`DCTV_S2_BAD_TRACK] = 1'b1;
						end else begin
							next_r.status_reg_2[`DCTV_S2_WRONG_TRACK] = 1'b1;
						end
					end else begin
						next_r.status_reg_1[`DCTV_S1_NO_DATA] = 1'b1;
					end
					next_r.state = DCTV_RESULT;
				end
			end
			DCTV_GAP: begin
				next_r.gap_cnt = r.gap_cnt - 8'd1;
				if (r.gap_cnt == 8'd0) begin
					next_r.state = DCTV_DATA;
				end
			end
			DCTV_DATA: begin
				if (r.opcode == `DCTV_OP_WRITE) begin
					if (wr_access && paddr_in == `DCTV_REG_CMD && !r.wr_valid) begin
						next_r.wr_byte = pwdata_in[7:0];
						next_r.wr_valid = 1'b1;
					end
					if (r.tc_sync[1]) begin
						next_r.state = DCTV_RESULT;
					end else if (wr_byte_ready_in && !r.wr_valid) begin
						next_r.status_reg_1[`DCTV_S1_OVERRUN] = 1'b1;
						next_r.status_reg_0 = 8'h40;
						next_r.state = DCTV_RESULT;
					end else if (data_done_in) begin
						next_r.state = DCTV_NEXT;
					end
				end else if (data_done_in || mark_missing_in) begin
					// terminal count plays no part here
					next_r.state = DCTV_NEXT;
					if (data_crc_err_in || mark_missing_in) begin
						next_r.status_reg_1[`DCTV_S1_CRC] = data_crc_err_in;
						next_r.status_reg_1[`DCTV_S1_MISSING] = mark_missing_in;
						next_r.status_reg_0 = 8'h40;
						next_r.state = DCTV_RESULT;
					end
				end
			end
			DCTV_NEXT: begin
				next_r.remaining = r.remaining - 9'd1;
				next_r.sector = r.sector + 8'd1;
				next_r.index_seen = 2'd0;
				next_r.state = DCTV_SEARCH;
				if (r.opcode == `DCTV_OP_VERIFY && r.count_enable && r.remaining == 9'd1) begin
					next_r.state = DCTV_RESULT;
				end else if (last_sector) begin
					if (r.multitrack_flag && r.head[0] == 1'b0) begin
						next_r.head = 8'd1;
						next_r.sector = 8'd1;
					end else begin
						if (r.opcode == `DCTV_OP_WRITE) begin
							next_r.status_reg_1[`DCTV_S1_EOT] = 1'b1;
							next_r.status_reg_0 = 8'h40;
						end
						next_r.state = DCTV_RESULT;
					end
				end
			end
			DCTV_RESULT: ;
			default: next_r.state = DCTV_IDLE;
		endcase
		if (wr_access && paddr_in == `DCTV_REG_TIMERS && r.state == DCTV_IDLE) begin
			next_r.timer_mode_select = pwdata_in[0];
		end
		next_r.rdata = 32'h0;
		unique case (paddr_in)
			`DCTV_REG_RESULT: begin
				if (r.opcode == `DCTV_OP_VERSION) begin
					next_r.rdata = {24'h0, (r.status_reg_0 == `DCTV_INVALID_BYTE)
						? `DCTV_INVALID_BYTE : VERSION_CODE};
				end else begin
					unique case (r.res_idx)
						3'd0: next_r.rdata = {24'h0, r.status_reg_0 | {5'd0, r.head[0], 2'd0}};
						3'd1: next_r.rdata = {24'h0, r.status_reg_1};
						3'd2: next_r.rdata = {24'h0, r.status_reg_2};
						3'd3: next_r.rdata = {24'h0, r.track};
						3'd4: next_r.rdata = {24'h0, r.head};
						3'd5: next_r.rdata = {24'h0, r.sector};
						default: next_r.rdata = {24'h0, r.size};
					endcase
				end
			end
			`DCTV_REG_STATUS: next_r.rdata = {24'h0, r.dma_mode, r.state == DCTV_RESULT,
				r.state != DCTV_IDLE, 1'b0, 4'(r.state)};
			`DCTV_REG_TIMERS: next_r.rdata = {4'h0, motor_off_ticks(r.motor_off_code,
				r.timer_mode_select, data_rate_in), 7'h0, r.timer_mode_select};
			`DCTV_REG_SECTORS: next_r.rdata = {23'h0, r.remaining};
			default: ;
		endcase
		if (sys_rst_in) begin
			next_r = '0;
			next_r.state = DCTV_IDLE;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		r <= next_r;
	end

	always_comb begin
		pready_out = r.ack;
		pslverr_out = r.ack && paddr_in != `DCTV_REG_CMD && paddr_in != `DCTV_REG_RESULT
			&& paddr_in != `DCTV_REG_STATUS && paddr_in != `DCTV_REG_TIMERS
			&& paddr_in != `DCTV_REG_SECTORS;
		prdata_out = r.rdata;
		step_out = r.step;
		sep_enable_out = (r.state == DCTV_SEARCH) || (r.state == DCTV_DATA)
			|| (r.state == DCTV_GAP);
		wr_gate_out = (r.state == DCTV_DATA) && (r.opcode == `DCTV_OP_WRITE);
		wr_byte_out = r.wr_byte;
		wr_byte_valid_out = r.wr_valid;
		dma_request_out = wr_gate_out && !r.dma_mode && !r.wr_valid;
		dma_mode_out = r.dma_mode;
		head_select_out = r.head;
	end
endmodule // dctv_engine

// ---- dctv_disk_model.sv ----
/*
 * Behavioural drive and separator: an address field every 300 cycles while
 * enabled, sectors 1 to 18, index near sector 1, a write byte pull every 16.
 * Assumes one clock shared with the engine.
 */
module dctv_disk_model (
	input wire logic sys_clk_in,
	input wire logic sys_rst_in,
	input wire logic sep_enable_in,
	input wire logic wr_gate_in,
	output logic id_valid_out,
	output logic [7:0] id_track_out,
	output logic [7:0] id_head_out,
	output logic [7:0] id_sector_out,
	output logic [7:0] id_size_out,
	output logic data_done_out,
	output logic index_out,
	output logic wr_byte_ready_out
);
	logic [8:0] slot;
	logic [7:0] sec;
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in || !sep_enable_in) begin
			slot <= 9'h000;
			sec <= 8'h01;
		end else begin
			slot <= (slot == 9'h12B) ? 9'h000 : slot + 9'h001;
			if (slot == 9'h12B)
				sec <= (sec == 8'h12) ? 8'h01 : sec + 8'h01;
		end
	end
	assign id_valid_out = sep_enable_in && slot == 9'h032;
	// outside the strobe track and head change every cycle, sector every other cycle, size per sector
	assign id_track_out = id_valid_out ? 8'h00 : slot[7:0];
	assign id_head_out = id_valid_out ? 8'h00 : ~slot[7:0];
	assign id_sector_out = id_valid_out ? sec : slot[8:1];
	assign id_size_out = id_valid_out ? 8'h02 : ~sec;
	assign data_done_out = sep_enable_in && slot == 9'h0FA;
	assign index_out = sep_enable_in && sec == 8'h01 && slot < 9'h014;
	assign wr_byte_ready_out = wr_gate_in && slot[3:0] == 4'hF;
endmodule // dctv_disk_model

// ---- dctv_engine_monitor.sv ----
/*
 * Port assertions for the command engine.
 * Assumes a bind to dctv_engine with each input named as its port.
 */
module dctv_monitor (
	input wire logic sys_clk_in,
	input wire logic sys_rst_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic pready_out,
	input wire logic pslverr_out,
	input wire logic step_out,
	input wire logic sep_enable_out,
	input wire logic wr_gate_out,
	input wire logic dma_request_out,
	input wire logic dma_mode_out
);
	default clocking @(posedge sys_clk_in);
	endclocking
	default disable iff (sys_rst_in);
	apb_one_wait_a: assert property (psel_in && penable_in && !pready_out |=> pready_out)
		else $error("ready not given after one wait");
	ready_cause_a: assert property (pready_out |-> psel_in && penable_in)
		else $error("ready outside an access");
	ready_single_a: assert property (pready_out |=> !pready_out)
		else $error("ready held too long");
	err_with_ready_a: assert property (pslverr_out |-> pready_out)
		else $error("error without ready");
	step_pulse_a: assert property (step_out |=> !step_out)
		else $error("step pulse too long");
	step_no_write_a: assert property (step_out |-> !wr_gate_out)
		else $error("step while writing");
	mode_by_write_a: assert property (
		!$stable(dma_mode_out) |-> $past(psel_in) && $past(penable_in) && $past(pwrite_in))
		else $error("transfer mode changed without a write");
	request_dma_a: assert property (dma_request_out |-> !dma_mode_out)
		else $error("dma request in programmed mode");
	gate_after_sep_a: assert property ($rose(wr_gate_out) |-> sep_enable_out)
		else $error("write gate without separator");
endmodule // dctv_monitor

// ---- dctv_engine_tb.sv ----
/*
 * Self-checking bench: apb tasks, command sequences and result checks.
 * Assumes the disk model and the monitor are compiled first.
 */
`include "dctv_defines.svh"
module dctv_engine_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic psel_in = 1'b0;
	logic penable_in = 1'b0;
	logic pwrite_in = 1'b0;
	logic [7:0] paddr_in = 8'h00;
	logic [31:0] pwdata_in = 32'h0;
	logic tc_in = 1'b0;
	logic write_protect_in = 1'b0;
	logic implied_seek_select_in = 1'b0;
	logic [1:0] data_rate_in = 2'b00;
	logic [31:0] prdata_out;
	logic pready_out, pslverr_out, step_out, sep_enable_out, wr_gate_out;
	logic wr_byte_valid_out, dma_request_out, dma_mode_out;
	logic id_valid_in, data_done_in, index_in, wr_byte_ready_in;
	logic [7:0] wr_byte_out, head_select_out, id_track_in, id_head_in, id_sector_in, id_size_in;
	logic [31:0] r;
	logic e;
	logic [7:0] res [7];
	int mismatches = 0;
	int check_count = 0;
	int steps = 0;
	int dma_reqs = 0;

	// step pulses and dma request cycles seen across the run
	always @(posedge sys_clk_in) begin
		if (step_out === 1'b1)
			steps++;
		if (dma_request_out === 1'b1)
			dma_reqs++;
	end

	dctv_engine uut (.sys_clk_in, .sys_rst_in, .psel_in, .penable_in, .pwrite_in,
		.paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out,
		.data_rate_in, .perpendicular_in(1'b0), .implied_seek_select_in, .tc_in,
		.index_in, .write_protect_in, .id_valid_in, .id_crc_err_in(1'b0), .id_track_in,
		.id_head_in, .id_sector_in, .id_size_in, .data_done_in, .data_crc_err_in(1'b0),
		.mark_missing_in(1'b0), .wr_byte_ready_in, .step_out, .sep_enable_out, .wr_gate_out,
		.wr_byte_out, .wr_byte_valid_out, .dma_request_out, .dma_mode_out, .head_select_out);

	dctv_disk_model disk (.sys_clk_in, .sys_rst_in, .sep_enable_in(sep_enable_out),
		.wr_gate_in(wr_gate_out), .id_valid_out(id_valid_in), .id_track_out(id_track_in),
		.id_head_out(id_head_in), .id_sector_out(id_sector_in), .id_size_out(id_size_in),
		.data_done_out(data_done_in), .index_out(index_in),
		.wr_byte_ready_out(wr_byte_ready_in));

	initial begin
		forever #20 sys_clk_in = ~sys_clk_in;
	end

	task report_and_stop;
		if (mismatches == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge sys_clk_in);
		psel_in <= 1'b1;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge sys_clk_in);
		penable_in <= 1'b1;
		// request held until the edge that finds ready high; data taken there
		do begin
			@(posedge sys_clk_in);
			n++;
		end while (pready_out !== 1'b1);
		r = prdata_out;
		e = pslverr_out;
		chk(32'(n), 32'h2);
		psel_in <= 1'b0;
		penable_in <= 1'b0;
	endtask

	task automatic cmd(input logic [71:0] b, input int n);
		for (int i = 0; i < n; i++)
			apb(1'b1, 8'h00, {24'h0, b[71 - 8 * i -: 8]});
	endtask

	// full command, wait for the result phase, then take all seven bytes
	task automatic exec(input logic [71:0] b);
		cmd(b, 9);
		do begin
			apb(1'b0, 8'h08, 32'h0);
		end while (r[6] !== 1'b1);
		for (int i = 0; i < 7; i++) begin
			apb(1'b0, 8'h04, 32'h0);
			res[i] = r[7:0];
		end
		apb(1'b0, 8'h08, 32'h0);
		chk(32'(r[5]), 32'h0);
	endtask

	initial begin
		repeat (20) @(posedge sys_clk_in);
		sys_rst_in <= 1'b0;
		apb(1'b0, 8'h20, 32'h0);
		chk(32'(e), 32'h1);
		cmd({8'h10, 64'h0}, 1);
		apb(1'b0, 8'h04, 32'h0);
		chk(32'(r[7:0]), 32'(`DCTV_VERSION_BYTE));
		cmd({8'h1F, 64'h0}, 1);
		apb(1'b0, 8'h04, 32'h0);
		chk(32'(r[7:0]), 32'h80);
		cmd({8'h03, 8'hF0, 8'h03, 48'h0}, 3);
		chk(32'(dma_mode_out), 32'h1);
		apb(1'b0, 8'h0C, 32'h0);
		chk(r, {7'h0, 17'd768, 8'h00});
		apb(1'b1, 8'h0C, 32'h1);
		apb(1'b0, 8'h0C, 32'h0);
		chk(r, {7'h0, 17'd49152, 8'h01});
		apb(1'b1, 8'h0C, 32'h0);
		cmd({8'h03, 8'hF2, 8'h02, 48'h0}, 3);
		chk(32'(dma_mode_out), 32'h0);
		apb(1'b0, 8'h0C, 32'h0);
		chk(r, {7'h0, 17'd96, 8'h00});
		data_rate_in <= 2'b11;
		apb(1'b0, 8'h0C, 32'h0);
		chk(r, {7'h0, 17'h00180, 8'h00});
		data_rate_in <= 2'b00;
		tc_in <= 1'b1;
		exec({8'h16, 8'h80, 8'h00, 8'h00, 8'h01, 8'h02, 8'h12, 8'h1B, 8'h02});
		chk(32'(res[0][7:6]), 32'h0);
		chk(32'(res[1]), 32'h0);
		tc_in <= 1'b0;
		exec({8'h16, 8'h00, 8'h00, 8'h00, 8'h01, 8'h02, 8'h14, 8'h1B, 8'hFF});
		chk(32'(res[0][7:6]), 32'h1);
		implied_seek_select_in <= 1'b1;
		exec({8'h05, 8'h00, 8'h00, 8'h00, 8'h03, 8'h02, 8'h12, 8'h1B, 8'hFF});
		chk(32'(res[0][7:6]), 32'h1);
		chk(32'(res[1][4]), 32'h1);
		chk(32'(res[5]), 32'h3);
		chk(32'(steps), 32'h1);
		chk(32'(dma_reqs != 0), 32'h1);
		chk(32'(head_select_out), 32'h0);
		chk(32'(wr_byte_valid_out), 32'h0);
		write_protect_in <= 1'b1;
		implied_seek_select_in <= 1'b0;
		exec({8'h05, 8'h00, 8'h00, 8'h00, 8'h03, 8'h02, 8'h12, 8'h1B, 8'hFF});
		chk(32'(res[0][7:6]), 32'h1);
		chk(32'(res[1][1]), 32'h1);
		chk(32'(steps), 32'h1);
		report_and_stop;
	end

	initial begin
		repeat (150000) @(posedge sys_clk_in);
		mismatches++;
		report_and_stop;
	end
endmodule // dctv_engine_tb

bind dctv_engine dctv_monitor mon (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
	.psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
	.pready_out(pready_out), .pslverr_out(pslverr_out), .step_out(step_out),
	.sep_enable_out(sep_enable_out), .wr_gate_out(wr_gate_out),
	.dma_request_out(dma_request_out), .dma_mode_out(dma_mode_out));
